//--- cmcr_pkg.sv
/*
 * Constants for the codec mode control register pair: control word
 * framing, register addresses, bit positions and reset values.
 * Assumes a single 25 MHz clock domain and an active-low reset.
 */
package cmcr_pkg;
   // ----------------------------------------------------------------
   // Control word framing
   // ----------------------------------------------------------------
   localparam int unsigned WORD_W      = 16;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned ADDR_HI     = 15;
   localparam int unsigned ADDR_LO     = 13;
   localparam int unsigned RD_POS      = 12;
   localparam int unsigned BCAST_POS   = 11;
   localparam int unsigned ONES_HI     = 10;
   localparam int unsigned ONES_LO     = 8;
   localparam logic [2:0]  ONES_VAL    = 3'h7;
   // ----------------------------------------------------------------
   // Register address codes
   // ----------------------------------------------------------------
   localparam logic [2:0]  ADDR_NOP    = 3'h0;
   localparam logic [2:0]  ADDR_MODE   = 3'h1;
   localparam logic [2:0]  ADDR_CLKHP  = 3'h2;
   // ----------------------------------------------------------------
   // Mode and status register fields
   // ----------------------------------------------------------------
   localparam int unsigned ADC_OVF_POS = 7;
   localparam int unsigned CONT_POS    = 6;
   localparam int unsigned RECUR_POS   = 5;
   localparam int unsigned DAC_OVF_POS = 4;
   localparam int unsigned BIAS_POS    = 3;
   localparam int unsigned ALOOP_POS   = 2;
   localparam int unsigned DLOOP_POS   = 1;
   localparam int unsigned WIDE_POS    = 0;
   // ----------------------------------------------------------------
   // Clock and host port register fields
   // ----------------------------------------------------------------
   localparam int unsigned TURBO_POS   = 7;
   localparam int unsigned BYPASS_POS  = 6;
   localparam int unsigned UPPER_HI    = 5;
   localparam int unsigned UPPER_LO    = 3;
   localparam int unsigned GPO_POS     = 2;
   localparam int unsigned HPC_HI      = 1;
   localparam int unsigned HPC_LO      = 0;
   localparam int unsigned CASCADE_W   = 4;
   localparam int unsigned BUS_ADDR_W  = 7;
   // ----------------------------------------------------------------
   // Host pin configurations and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0]  HPC_I2C     = 2'h0;
   localparam logic [1:0]  HPC_SSC     = 2'h1;
   localparam logic [1:0]  HPC_GPIO    = 2'h2;
   localparam logic [1:0]  HPC_FLAG    = 2'h3;
   localparam logic [2:0]  UPPER_RST   = 3'h4;
   localparam logic [1:0]  HPC_RST     = 2'h0;
   localparam logic        BIT_RST     = 1'b0;
endpackage : cmcr_pkg

//--- cmcr_regs.sv
/*
 * Mode/status and clock/host-port control registers for both channels
 * of a dual-channel voice codec, reached by 16-bit control words.
 * Assumes the serial or host port front end hands over whole control
 * words with a one-cycle strobe and the addressed channel, and that
 * converter overflow, sample tick and DAC word info are synchronous.
 */
// Summary of operation
// - Mode register bit 7 reads ADC overflow, read-only, resets 0
// - Mode register bit 4 reads DAC overflow, read-only, resets 0
// - Bit 6, shadowed, picks programming (0) or continuous (1) transfer
// - Bit 5 picks FIR (0, reset) or RECURSIVE_FILTER_SEL (1) low-pass filters
// - Bit 3, shadowed, selects one of two bias pin voltages
// - Bit 2 enables analog loopback, resets 0
// - Bit 1 enables digital loopback, resets 0
// - Bit 0, shadowed, gives 15- or 16-bit DAC words in continuous mode
// - 15-bit continuous mode: DAC word LSB of 1 returns to programming mode
// - Clock register bit 7 selects frame-based or divided-master bit clock
// - Bit 6 bypasses decimation and interpolation filters, resets 0
// - Bits 5..3, reset 100, are upper bits of the 7-bit bus address
// - Bits 1..0 select two-wire protocol: 00 I2C, 01 start-stop
// - Config 10: data pin shows output bit, clock pin forwarded out
// - Config 11: data pin shows the control frame flag
// - Whole clock register and mode, bias, width bits are shadowed
// - Shadowed bits written on one channel update both channels together
// - Word: address 15..13, read bit 12, broadcast 11, ones 10..8, data 7..0
// - Address 001 is mode register, 010 clock register, 000 no operation
`timescale 1ns/1ps
module cmcr_regs (
   input  wire logic                              clk_i,
   input  wire logic                              resetn_i,
   input  wire logic                              ce_i,
   input  wire logic                              word_valid_i,
   input  wire logic [cmcr_pkg::WORD_W-1:0]       word_i,
   input  wire logic                              word_chan_i,
   output logic                                   rd_valid_o,
   output logic      [cmcr_pkg::DATA_W-1:0]       rd_data_o,
   output logic                                   broadcast_o,
   input  wire logic                              sample_tick_i,
   input  wire logic [1:0]                        adc_ovf_i,
   input  wire logic [1:0]                        dac_ovf_i,
   input  wire logic                              dac_word_valid_i,
   input  wire logic                              dac_word_lsb_i,
   input  wire logic [cmcr_pkg::CASCADE_W-1:0]    cascade_addr_i,
   input  wire logic                              frame_flag_i,
   input  wire logic                              scl_i,
   output logic                                   sda_o,
   output logic                                   sda_oe_o,
   output logic                                   serial_out_o,
   output logic                                   serial_out_sel_o,
   output logic                                   continuous_transfer_sel_o,
   output logic      [1:0]                        recursive_filter_sel_o,
   output logic                                   bias_level_sel_o,
   output logic      [1:0]                        analog_loop_en_o,
   output logic      [1:0]                        digital_loop_en_o,
   output logic                                   dac_wide_word_en_o,
   output logic                                   bit_clk_turbo_o,
   output logic                                   filter_bypass_en_o,
   output logic      [cmcr_pkg::BUS_ADDR_W-1:0]   bus_addr_o,
   output logic      [1:0]                        host_pin_config_o
);
   import cmcr_pkg::*;

   // ----------------------------------------------------------------
   // Control word decode
   // ----------------------------------------------------------------
   // Word is taken only with the fixed ones field in place
   function automatic logic word_hits(input logic [WORD_W-1:0] w, input logic [2:0] a);
      word_hits = (w[ADDR_HI:ADDR_LO] == a) && (w[ONES_HI:ONES_LO] == ONES_VAL);
   endfunction : word_hits

   logic             take;
   logic             wr_mode;
   logic             wr_clk;
   logic             rd_any;
   logic [DATA_W-1:0] wdata;

   // Strobes for the two registers
   assign take    = ce_i && word_valid_i;
   assign wdata   = word_i[DATA_W-1:0];
   assign wr_mode = take && !word_i[RD_POS] && word_hits(word_i, ADDR_MODE);
   assign wr_clk  = take && !word_i[RD_POS] && word_hits(word_i, ADDR_CLKHP);
   assign rd_any  = take && word_i[RD_POS]
                    && (word_hits(word_i, ADDR_MODE) || word_hits(word_i, ADDR_CLKHP));

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic       cont;
   logic       bias;
   logic       wide;
   logic [1:0] recur;
   logic [1:0] aloop;
   logic [1:0] dloop;
   logic [1:0] adc_flag;
   logic [1:0] dac_flag;
   logic [DATA_W-1:0] clkhp;
   logic       next_cont;
   logic       next_bias;
   logic       next_wide;
   logic [1:0] next_recur;
   logic [1:0] next_aloop;
   logic [1:0] next_dloop;
   logic [1:0] next_adc_flag;
   logic [1:0] next_dac_flag;
   logic [DATA_W-1:0] next_clkhp;
   logic       cont_exit;

   // Leaving continuous mode on a 15-bit DAC word with LSB set
   assign cont_exit = cont && !wide && dac_word_valid_i && dac_word_lsb_i;

   // Next values of shadowed and per-channel fields
   always_comb begin
      next_cont     = cont;
      next_bias     = bias;
      next_wide     = wide;
      next_recur    = recur;
      next_aloop    = aloop;
      next_dloop    = dloop;
      next_clkhp    = clkhp;
      next_adc_flag = adc_flag;
      next_dac_flag = dac_flag;
      if (cont_exit) begin
         next_cont = 1'b0;
      end
      if (wr_mode) begin
         next_cont  = wdata[CONT_POS];
         next_bias  = wdata[BIAS_POS];
         next_wide  = wdata[WIDE_POS];
         next_recur[word_chan_i] = wdata[RECUR_POS];
         next_aloop[word_chan_i] = wdata[ALOOP_POS];
         next_dloop[word_chan_i] = wdata[DLOOP_POS];
      end
      if (wr_clk) begin
         next_clkhp = wdata;
      end
      if (sample_tick_i) begin
         next_adc_flag = adc_ovf_i;
         next_dac_flag = dac_ovf_i;
      end
   end

   // Register update, frozen while the clock enable is low
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cont     <= BIT_RST;
         bias     <= BIT_RST;
         wide     <= BIT_RST;
         recur    <= {2{BIT_RST}};
         aloop    <= {2{BIT_RST}};
         dloop    <= {2{BIT_RST}};
         adc_flag <= {2{BIT_RST}};
         dac_flag <= {2{BIT_RST}};
         clkhp    <= {BIT_RST, BIT_RST, UPPER_RST, BIT_RST, HPC_RST};
      end else if (ce_i) begin
         cont     <= next_cont;
         bias     <= next_bias;
         wide     <= next_wide;
         recur    <= next_recur;
         aloop    <= next_aloop;
         dloop    <= next_dloop;
         adc_flag <= next_adc_flag;
         dac_flag <= next_dac_flag;
         clkhp    <= next_clkhp;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic              next_rd_valid;
   logic [DATA_W-1:0] next_rd_data;

   // Assemble the addressed channel's view of the register
   always_comb begin
      next_rd_valid = 1'b0;
      next_rd_data  = rd_data_o;
      if (ce_i) begin
         next_rd_valid = rd_any;
      end
      if (rd_any && word_i[ADDR_HI:ADDR_LO] == ADDR_MODE) begin
         next_rd_data = '0;
         next_rd_data[ADC_OVF_POS] = adc_flag[word_chan_i];
         next_rd_data[CONT_POS]    = cont;
         next_rd_data[RECUR_POS]   = recur[word_chan_i];
         next_rd_data[DAC_OVF_POS] = dac_flag[word_chan_i];
         next_rd_data[BIAS_POS]    = bias;
         next_rd_data[ALOOP_POS]   = aloop[word_chan_i];
         next_rd_data[DLOOP_POS]   = dloop[word_chan_i];
         next_rd_data[WIDE_POS]    = wide;
      end else if (rd_any) begin
         next_rd_data = clkhp;
      end
   end

   // Read answer registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_valid_o <= 1'b0;
         rd_data_o  <= '0;
      end else if (ce_i) begin
         rd_valid_o <= next_rd_valid;
         rd_data_o  <= next_rd_data;
      end else begin
         rd_valid_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Host pin use
   // ----------------------------------------------------------------
   logic next_sda;
   logic next_sda_oe;
   logic next_serial_out;
   logic next_serial_sel;
   logic next_bcast;

   // Data pin driven only in the general output and frame flag uses
   always_comb begin
      next_sda        = 1'b0;
      next_sda_oe     = 1'b0;
      next_serial_out = 1'b0;
      next_serial_sel = 1'b0;
      next_bcast      = broadcast_o;
      if (wr_mode || wr_clk) begin
         next_bcast = word_i[BCAST_POS];
      end
      unique case (clkhp[HPC_HI:HPC_LO])
         HPC_I2C, HPC_SSC: begin
            next_sda_oe = 1'b0;
         end
         HPC_GPIO: begin
            next_sda        = clkhp[GPO_POS];
            next_sda_oe     = 1'b1;
            next_serial_out = scl_i;
            next_serial_sel = 1'b1;
         end
         HPC_FLAG: begin
            next_sda    = frame_flag_i;
            next_sda_oe = 1'b1;
         end
      endcase
   end

   // Pin output registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sda_o            <= 1'b0;
         sda_oe_o         <= 1'b0;
         serial_out_o     <= 1'b0;
         serial_out_sel_o <= 1'b0;
         broadcast_o      <= 1'b0;
      end else if (ce_i) begin
         sda_o            <= next_sda;
         sda_oe_o         <= next_sda_oe;
         serial_out_o     <= next_serial_out;
         serial_out_sel_o <= next_serial_sel;
         broadcast_o      <= next_bcast;
      end
   end

   // ----------------------------------------------------------------
   // Control outputs
   // ----------------------------------------------------------------
   // Field outputs straight from the register flops; bus address low bits come from cascade_addr_i
   assign continuous_transfer_sel_o = cont;
   assign recursive_filter_sel_o    = recur;
   assign bias_level_sel_o          = bias;
   assign analog_loop_en_o          = aloop;
   assign digital_loop_en_o         = dloop;
   assign dac_wide_word_en_o        = wide;
   assign bit_clk_turbo_o           = clkhp[TURBO_POS];
   assign filter_bypass_en_o        = clkhp[BYPASS_POS];
   assign bus_addr_o = {clkhp[UPPER_HI:UPPER_LO], cascade_addr_i};
   assign host_pin_config_o         = clkhp[HPC_HI:HPC_LO];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_adc_flag_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && sample_tick_i ##1 ce_i && word_valid_i && word_i[RD_POS] && word_hits(word_i, ADDR_MODE)
      |=> rd_valid_o && rd_data_o[ADC_OVF_POS] == ($past(word_chan_i) ? $past(adc_ovf_i[1], 2)
                                                                      : $past(adc_ovf_i[0], 2)))
      else $error("ADC overflow bit reads wrong");
   chk_ovf_write_ignored: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_mode && !sample_tick_i |=> $stable(adc_flag) && $stable(dac_flag))
      else $error("Overflow flags changed by a write");
   chk_cont_exit: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && cont_exit && !wr_mode |=> !continuous_transfer_sel_o)
      else $error("Continuous mode not left on LSB word");
   chk_shadow_cont: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_mode |=> continuous_transfer_sel_o == $past(wdata[CONT_POS])
                  && dac_wide_word_en_o == $past(wdata[WIDE_POS]))
      else $error("Shadowed bit not applied");
   chk_chan_private: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_mode && !word_chan_i |=> $stable(recursive_filter_sel_o[1]) && $stable(analog_loop_en_o[1]))
      else $error("Other channel private bit changed");
   chk_addr_upper: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_clk |=> bus_addr_o[BUS_ADDR_W-1:CASCADE_W] == $past(wdata[UPPER_HI:UPPER_LO]))
      else $error("Bus address upper bits wrong");
   chk_gpio_fwd: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && host_pin_config_o == HPC_GPIO |=> sda_oe_o && serial_out_o == $past(scl_i))
      else $error("Clock pin not forwarded");
   chk_flag_pin: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && host_pin_config_o == HPC_FLAG |=> sda_oe_o && sda_o == $past(frame_flag_i))
      else $error("Frame flag not on data pin");
   chk_noop_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && word_i[ADDR_HI:ADDR_LO] == ADDR_NOP |=> !rd_valid_o ##0 $stable(clkhp))
      else $error("No-op address had an effect");
endmodule : cmcr_regs

//--- cmcr_host.sv
/*
 * Host model for the codec mode control registers: hands over whole
 * 16-bit control words with a one-cycle strobe and collects read answers.
 * Assumes the registers take a word at the rising edge with strobe high.
 */
`timescale 1ns/1ps
module cmcr_host (
   input  wire logic                         clk_i,
   output logic                              word_valid_o,
   output logic [cmcr_pkg::WORD_W-1:0]       word_o,
   output logic                              word_chan_o,
   input  wire logic                         rd_valid_i,
   input  wire logic [cmcr_pkg::DATA_W-1:0]  rd_data_i
);
   import cmcr_pkg::*;
   // Idle bus at time zero
   initial begin
      word_valid_o = 1'b0;
      word_o       = 16'h0000;
      word_chan_o  = 1'b0;
   end
   // One word per strobe; released lines show the inverse of the last value
   task automatic xfer(input logic [15:0] w, input logic ch, output logic ok, output logic [7:0] d);
      ok = 1'b0;
      d  = 8'h00;
      @(posedge clk_i);
      word_valid_o <= 1'b1;
      word_o       <= w;
      word_chan_o  <= ch;
      @(posedge clk_i);
      word_valid_o <= 1'b0;
      word_o       <= ~w;
      word_chan_o  <= ~ch;
      // Answer is awaited for a bounded three cycles
      for (int i = 0; i < 3; i++) begin
         @(negedge clk_i);
         if (rd_valid_i === 1'b1 && ok === 1'b0) begin
            ok = 1'b1;
            d  = rd_data_i;
         end
      end
   endtask : xfer
endmodule : cmcr_host

//--- cmcr_regs_tb.sv
/*
 * Self-checking bench for the codec mode control registers.
 * Assumes the host model in cmcr_host and a 25 MHz clock.
 */
`timescale 1ns/1ps
module cmcr_regs_tb;
   import cmcr_pkg::*;
   logic clk_i = 0, resetn_i = 0, ce_i = 1, sample_tick_i = 0, dac_word_valid_i = 0, dac_word_lsb_i = 0;
   logic frame_flag_i = 0, scl_i = 0, word_valid_i, word_chan_i, rd_valid_o, broadcast_o;
   logic [1:0] adc_ovf_i = 0, dac_ovf_i = 0, recur_o, aloop_o, dloop_o, hpc_o;
   logic [3:0] cascade_addr_i = 4'h5;
   logic [15:0] word_i;
   logic [7:0] rd_data_o;
   logic [6:0] bus_addr_o;
   logic sda_o, sda_oe_o, ser_o, ser_sel_o, cont_o, bias_o, wide_o, turbo_o, bypass_o;
   int err_count = 0, num_checks = 0;
   // ----------------------------------------------------------------
   // Clock, device and host
   // ----------------------------------------------------------------
   always #20 clk_i = ~clk_i;
   cmcr_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .word_valid_i(word_valid_i),
      .word_i(word_i), .word_chan_i(word_chan_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
      .broadcast_o(broadcast_o), .sample_tick_i(sample_tick_i), .adc_ovf_i(adc_ovf_i),
      .dac_ovf_i(dac_ovf_i), .dac_word_valid_i(dac_word_valid_i), .dac_word_lsb_i(dac_word_lsb_i),
      .cascade_addr_i(cascade_addr_i), .frame_flag_i(frame_flag_i), .scl_i(scl_i), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .serial_out_o(ser_o), .serial_out_sel_o(ser_sel_o),
      .continuous_transfer_sel_o(cont_o), .recursive_filter_sel_o(recur_o), .bias_level_sel_o(bias_o),
      .analog_loop_en_o(aloop_o), .digital_loop_en_o(dloop_o), .dac_wide_word_en_o(wide_o),
      .bit_clk_turbo_o(turbo_o), .filter_bypass_en_o(bypass_o), .bus_addr_o(bus_addr_o),
      .host_pin_config_o(hpc_o));
   cmcr_host host (.clk_i(clk_i), .word_valid_o(word_valid_i), .word_o(word_i), .word_chan_o(word_chan_i),
      .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] wd(logic [2:0] a, logic r, logic bc, logic [7:0] d);
      return {a, r, bc, ONES_VAL, d};
   endfunction : wd
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Plain word exchange; a read answer is expected only when want is set
   task automatic xw(input logic [15:0] w, input logic ch, input logic want, input logic [7:0] exp);
      logic ok;
      logic [7:0] d;
      host.xfer(w, ch, ok, d);
      chk({7'h0, ok}, {7'h0, want});
      if (want) chk(d, exp);
   endtask : xw
   task automatic pulse(input logic tick, input logic lsb);
      @(posedge clk_i);
      sample_tick_i    <= tick;
      dac_word_valid_i <= !tick;
      dac_word_lsb_i   <= lsb;
      @(posedge clk_i);
      sample_tick_i    <= 1'b0;
      dac_word_valid_i <= 1'b0;
      repeat (2) @(negedge clk_i);
   endtask : pulse
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(negedge clk_i);
      chk({1'b0, bus_addr_o}, {1'b0, UPPER_RST, 4'h5});
      chk({cont_o, bias_o, wide_o, turbo_o, bypass_o, hpc_o, sda_oe_o}, 8'h00);
      chk({recur_o, aloop_o, dloop_o, broadcast_o, 1'b0}, 8'h00);
      xw(wd(ADDR_MODE, 1, 0, 0), 0, 1, 8'h00);
   endtask : t_reset
   task automatic t_ovf();
      @(posedge clk_i);
      adc_ovf_i     <= 2'b10;
      dac_ovf_i     <= 2'b01;
      sample_tick_i <= 1'b1;
      // Read strobe follows the sample tick directly
      fork
         begin
            @(posedge clk_i);
            sample_tick_i <= 1'b0;
         end
         xw(wd(ADDR_MODE, 1, 0, 0), 1, 1, 8'h80);
      join
      xw(wd(ADDR_MODE, 1, 0, 0), 0, 1, 8'h10);
      @(posedge clk_i);
      adc_ovf_i <= 2'b00;
      dac_ovf_i <= 2'b00;
      pulse(1, 0);
      xw(wd(ADDR_MODE, 1, 0, 0), 1, 1, 8'h00);
   endtask : t_ovf
   task automatic t_shadow();
      xw(wd(ADDR_MODE, 0, 0, 8'hFF), 0, 0, 0);
      xw(wd(ADDR_MODE, 1, 0, 0), 0, 1, 8'h6F);
      xw(wd(ADDR_MODE, 1, 0, 0), 1, 1, 8'h49);
      chk({1'b0, cont_o, bias_o, wide_o, recur_o, aloop_o[0], dloop_o[0]}, 8'h77);
      xw(wd(ADDR_MODE, 0, 0, 8'h00), 1, 0, 0);
      xw(wd(ADDR_MODE, 1, 0, 0), 0, 1, 8'h26);
   endtask : t_shadow
   task automatic t_cont();
      xw(wd(ADDR_MODE, 0, 0, 8'h40), 0, 0, 0);
      pulse(0, 0);
      chk({7'h0, cont_o}, 8'h01);
      pulse(0, 1);
      chk({7'h0, cont_o}, 8'h00);
      xw(wd(ADDR_MODE, 0, 0, 8'h41), 0, 0, 0);
      pulse(0, 1);
      chk({6'h0, cont_o, wide_o}, 8'h03);
   endtask : t_cont
   task automatic t_refuse();
      xw(wd(ADDR_NOP, 1, 0, 0), 0, 0, 0);
      xw(16'h3500, 0, 0, 0);
      xw(wd(3'h3, 1, 0, 0), 0, 0, 0);
      xw(wd(ADDR_NOP, 0, 0, 8'h00), 0, 0, 0);
      @(posedge clk_i);
      ce_i <= 1'b0;
      xw(wd(ADDR_MODE, 1, 0, 0), 0, 0, 0);
      @(posedge clk_i);
      ce_i <= 1'b1;
      xw(wd(ADDR_MODE, 1, 0, 0), 0, 1, 8'h41);
   endtask : t_refuse
   task automatic t_pins();
      for (int h = 0; h < 4; h++) begin
         xw(wd(ADDR_CLKHP, 0, 1, {5'b11010, 1'b1, h[1:0]}), 1, 0, 0);
         chk({turbo_o, bypass_o, broadcast_o, 3'h0, hpc_o}, {5'h1C, 1'b0, h[1:0]});
         chk({1'b0, bus_addr_o}, 8'h25);
         chk({7'h0, sda_oe_o}, {7'h0, h[1]});
         for (int v = 1; v >= 0; v--) begin
            @(posedge clk_i);
            scl_i        <= v[0];
            frame_flag_i <= v[0];
            repeat (3) @(negedge clk_i);
            if (h == 2) chk({ser_sel_o, ser_o, sda_o}, {2'b11 & {1'b1, v[0]}, 1'b1});
            if (h == 3) chk({6'h0, ser_sel_o, sda_o}, {7'h0, v[0]});
         end
      end
   endtask : t_pins
   task automatic results();
      $display("Checks %0d, errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      t_reset();
      t_ovf();
      t_shadow();
      t_cont();
      t_refuse();
      t_pins();
      t_reset();
      results();
   end
endmodule : cmcr_regs_tb
